/* verilog/ums_pkg.sv */
// Package with constants and types for the modem status and feature control block.
`default_nettype none
package ums_pkg;

    // ==========================================================================
    // Register offsets on the plain register port.
    localparam logic [2:0] UMS_ADDR_MCTL  = 3'h0;
    localparam logic [2:0] UMS_ADDR_MSTAT = 3'h1;
    localparam logic [2:0] UMS_ADDR_SCR   = 3'h2;
    localparam logic [2:0] UMS_ADDR_FEAT  = 3'h3;
    localparam logic [2:0] UMS_ADDR_ENHF  = 3'h4;
    localparam logic [2:0] UMS_ADDR_RXTRG = 3'h5;

    // ==========================================================================
    // Field positions.
    localparam int UMS_MCTL_DTR     = 0;
    localparam int UMS_MCTL_RTS     = 1;
    localparam int UMS_MCTL_SEL     = 2;
    localparam int UMS_MCTL_OUT2    = 3;
    localparam int UMS_MCTL_LOOP    = 4;
    localparam int UMS_MCTL_ENH_LO  = 5;
    localparam int UMS_ENHF_ENH     = 4;
    localparam int UMS_ENHF_ARTS    = 6;
    localparam int UMS_ENHF_ACTS    = 7;
    localparam int UMS_FEAT_HYS_LO  = 0;
    localparam int UMS_FEAT_IRINV   = 4;
    localparam int UMS_FEAT_RS485   = 5;
    localparam int UMS_FEAT_TBL_LO  = 6;
    localparam int UMS_DLY_LO       = 4;

    // ==========================================================================
    // Values after reset.
    localparam logic [7:0] UMS_MCTL_RST  = 8'h00;
    localparam logic [7:0] UMS_ENHF_RST  = 8'h00;
    localparam logic [7:0] UMS_FEAT_RST  = 8'h00;
    localparam logic [7:0] UMS_SCR_RST   = 8'hff;
    localparam logic [7:0] UMS_RXTRG_RST = 8'h00;
    localparam logic [3:0] UMS_DLY_RST   = 4'h0;

    // ==========================================================================
    // Trigger tables, FIFO depth and hysteresis decode.
    localparam logic [1:0] UMS_TBL_A = 2'h0;
    localparam logic [1:0] UMS_TBL_B = 2'h1;
    localparam logic [1:0] UMS_TBL_C = 2'h2;
    localparam logic [1:0] UMS_TBL_D = 2'h3;
    localparam logic [8:0] UMS_FIFO_DEPTH = 9'h040;
    // Receive trigger levels per table, index 3 is the highest level.
    localparam logic [3:0][3:0][7:0] UMS_TRIG_LVL = '{
        '{8'h00, 8'h00, 8'h00, 8'h00},
        '{8'h3c, 8'h38, 8'h10, 8'h08},
        '{8'h1c, 8'h18, 8'h10, 8'h08},
        '{8'h0e, 8'h08, 8'h04, 8'h01}
    };
    // Hysteresis in characters, indexed by the four-bit code.
    localparam logic [15:0][7:0] UMS_HYST_LUT = '{
        8'h24, 8'h1c, 8'h14, 8'h0c, 8'h34, 8'h30, 8'h2c, 8'h28,
        8'h20, 8'h18, 8'h10, 8'h08, 8'h08, 8'h06, 8'h04, 8'h00
    };

    // ==========================================================================
    // Types.
    typedef enum logic [1:0] {
        UMS_RS_IDLE,
        UMS_RS_SEND,
        UMS_RS_TURN
    } ums_rs_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ums_bus_s;

    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ums_modem_in_s;

    typedef struct packed {
        logic hold_empty;
        logic shift_empty;
        logic tx_load;
        logic bit_tick;
    } ums_tx_stat_s;

    typedef struct packed {
        logic [7:0] mctl;
        logic [7:0] enhf;
        logic [7:0] feat;
        logic [7:0] scr;
        logic [7:0] rx_trig;
        logic [3:0] delay;
        logic       flow_block;
        ums_rs_e    rs_state;
        logic [3:0] turn_cnt;
        logic [7:0] rdata;
        logic       tx_int;
        logic       tx_halt;
        logic       rts_n;
        logic       dtr_n;
        logic       ir_rx;
    } ums_state_s;

    localparam ums_state_s UMS_STATE_RST = '{
        mctl:       UMS_MCTL_RST,
        enhf:       UMS_ENHF_RST,
        feat:       UMS_FEAT_RST,
        scr:        UMS_SCR_RST,
        rx_trig:    UMS_RXTRG_RST,
        delay:      UMS_DLY_RST,
        flow_block: 1'b0,
        rs_state:   UMS_RS_IDLE,
        turn_cnt:   4'h0,
        rdata:      8'h00,
        tx_int:     1'b1,
        tx_halt:    1'b0,
        rts_n:      1'b1,
        dtr_n:      1'b1,
        ir_rx:      1'b0
    };

endpackage : ums_pkg
`default_nettype wire

/* verilog/ums_flow_thresh.sv */
// Flow control threshold calculator for the automatic RTS/DTR logic.
`timescale 1ns/10ps
`default_nettype none
module ums_flow_thresh (
    input  wire logic [1:0] table_sel,
    input  wire logic [7:0] rx_trig,
    input  wire logic [3:0] hyst_code,
    output logic      [8:0] stop_lvl,
    output logic      [8:0] go_lvl
);

    logic [1:0] idx;
    logic [8:0] hyst;
    logic [8:0] trig;

    // ==========================================================================
    // Thresholds.
    always_comb begin
        idx  = rx_trig[1:0];
        hyst = {1'b0, ums_pkg::UMS_HYST_LUT[hyst_code]};
        trig = {1'b0, rx_trig};
        if (table_sel == ums_pkg::UMS_TBL_D) begin // RULE10
            stop_lvl = trig + hyst; // RULE11 RULE12
            go_lvl   = (trig > hyst) ? (trig - hyst) : 9'h000; // RULE12
        end else begin
            // Next level above (FIFO depth at the top) and below (level 0 itself at the bottom) the chosen one.
            if (idx == 2'h3) begin // RULE19
                stop_lvl = ums_pkg::UMS_FIFO_DEPTH;
            end else begin
                stop_lvl = {1'b0, ums_pkg::UMS_TRIG_LVL[table_sel][idx + 2'h1]};
            end
            if (idx == 2'h0) begin
                go_lvl = {1'b0, ums_pkg::UMS_TRIG_LVL[table_sel][2'h0]};
            end else begin
                go_lvl = {1'b0, ums_pkg::UMS_TRIG_LVL[table_sel][idx - 2'h1]};
            end
        end
    end

endmodule : ums_flow_thresh
`default_nettype wire

/* verilog/ums_modem_feature.sv */
// One channel of modem status, flow control, RS-485 direction and feature registers.
//
// Overview of operation
// RULE1 - Auto-CTS gating needs enable bit and RTS/CTS pair.
// RULE2 - CTS high halts after current character; low resumes.
// RULE3 - Status bit 4 is inverted CTS, loopback RTS.
// RULE4 - Status bit 5 is inverted DSR, loopback DTR.
// RULE5 - Status bit 6 is inverted RI, loopback control bit 2.
// RULE6 - Status bit 7 is inverted CD, loopback control bit 3.
// RULE7 - Status write upper nibble sets turnaround delay.
// RULE8 - Delay writes need enhanced-function enable set.
// RULE9 - Scratch register keeps data, resets to all ones.
// RULE10 - Hysteresis code used only with table D.
// RULE11 - Hysteresis code decodes to fixed character counts.
// RULE12 - Deassert at trigger plus hysteresis, reassert below minus.
// RULE13 - Reset clears hysteresis code to zero.
// RULE14 - IrDA receive polarity bit inverts encoded input.
// RULE15 - Without RS-485, interrupt on holding register empty.
// RULE16 - RS-485 RTS high on load, low after stop.
// RULE17 - With RS-485, interrupt on shift register empty.
// RULE18 - Two-bit field selects trigger table A to D.
// RULE19 - Tables A to C use next levels around trigger.
// RULE20 - Select bit chooses RTS/CTS or DTR/DSR pins.
// RULE21 - Enhanced bits frozen while enhanced enable is clear.
// RULE22 - Table field codes 00 to 11 mean A to D.
// RULE23 - Turnaround delay counts bit times after final stop.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ums_modem_feature (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire ums_pkg::ums_bus_s       bus,
    output logic                   [7:0] rdata,
    input  wire ums_pkg::ums_modem_in_s  modem_in,
    input  wire ums_pkg::ums_tx_stat_s   tx_stat,
    input  wire logic              [6:0] rx_level,
    input  wire logic                    ir_rx_in,
    output logic                         ir_rx_data,
    output logic                         tx_halt,
    output logic                         tx_int,
    output logic                         rts_n,
    output logic                         dtr_n
);

    ums_pkg::ums_state_s st_r;
    ums_pkg::ums_state_s st_nxt;

    logic [7:0] mstat_rd;
    logic [8:0] stop_lvl;
    logic [8:0] go_lvl;
    logic [8:0] level;
    logic       loop_en;
    logic       enh_en;
    logic       auto_rts;
    logic       auto_cts;
    logic       pair_sel;
    logic       rs485_en;

    // ==========================================================================
    // Flow control thresholds.
    ums_flow_thresh u_thresh (
        .table_sel (st_r.feat[ums_pkg::UMS_FEAT_TBL_LO +: 2]),
        .rx_trig   (st_r.rx_trig),
        .hyst_code (st_r.feat[ums_pkg::UMS_FEAT_HYS_LO +: 4]),
        .stop_lvl  (stop_lvl),
        .go_lvl    (go_lvl)
    );

    // ==========================================================================
    // Decoded control bits.
    always_comb begin
        loop_en  = st_r.mctl[ums_pkg::UMS_MCTL_LOOP];
        enh_en   = st_r.enhf[ums_pkg::UMS_ENHF_ENH];
        auto_rts = st_r.enhf[ums_pkg::UMS_ENHF_ARTS];
        auto_cts = st_r.enhf[ums_pkg::UMS_ENHF_ACTS];
        pair_sel = st_r.mctl[ums_pkg::UMS_MCTL_SEL];
        rs485_en = st_r.feat[ums_pkg::UMS_FEAT_RS485];
        level    = {2'b00, rx_level};
    end

    // ==========================================================================
    // Modem input status.
    always_comb begin
        mstat_rd    = 8'h00;
        if (loop_en) begin
            mstat_rd[4] = st_r.mctl[ums_pkg::UMS_MCTL_RTS]; // RULE3
            mstat_rd[5] = st_r.mctl[ums_pkg::UMS_MCTL_DTR]; // RULE4
            mstat_rd[6] = st_r.mctl[ums_pkg::UMS_MCTL_SEL]; // RULE5
            mstat_rd[7] = st_r.mctl[ums_pkg::UMS_MCTL_OUT2]; // RULE6
        end else begin
            mstat_rd[4] = ~modem_in.cts_n; // RULE3
            mstat_rd[5] = ~modem_in.dsr_n; // RULE4
            mstat_rd[6] = ~modem_in.ri_n; // RULE5
            mstat_rd[7] = ~modem_in.cd_n; // RULE6
        end
    end

    // ==========================================================================
    // Next state.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = 8'h00;

        // Register writes.
        if (bus.wr) begin
            unique case (bus.addr)
                ums_pkg::UMS_ADDR_MCTL: begin
                    if (enh_en) begin
                        st_nxt.mctl = bus.wdata;
                    end else begin
                        // Upper bits hold their value while latched.
                        st_nxt.mctl = {st_r.mctl[7:ums_pkg::UMS_MCTL_ENH_LO],
                                       bus.wdata[ums_pkg::UMS_MCTL_ENH_LO-1:0]}; // RULE21
                    end
                end
                ums_pkg::UMS_ADDR_MSTAT: begin
                    if (enh_en) begin // RULE8 RULE21
                        st_nxt.delay = bus.wdata[ums_pkg::UMS_DLY_LO +: 4]; // RULE7
                    end
                end
                ums_pkg::UMS_ADDR_SCR: begin
                    st_nxt.scr = bus.wdata; // RULE9
                end
                ums_pkg::UMS_ADDR_FEAT: begin
                    st_nxt.feat = bus.wdata; // RULE18 RULE22
                end
                ums_pkg::UMS_ADDR_ENHF: begin
                    st_nxt.enhf = bus.wdata;
                end
                ums_pkg::UMS_ADDR_RXTRG: begin
                    st_nxt.rx_trig = bus.wdata;
                end
                default: begin
                    st_nxt.rx_trig = st_r.rx_trig;
                end
            endcase
        end

        // Register reads, answered in the following cycle.
        if (bus.rd) begin
            unique case (bus.addr)
                ums_pkg::UMS_ADDR_MCTL: begin
                    st_nxt.rdata = st_r.mctl;
                end
                ums_pkg::UMS_ADDR_MSTAT: begin
                    st_nxt.rdata = mstat_rd;
                end
                ums_pkg::UMS_ADDR_SCR: begin
                    st_nxt.rdata = st_r.scr; // RULE9
                end
                ums_pkg::UMS_ADDR_FEAT: begin
                    st_nxt.rdata = st_r.feat;
                end
                ums_pkg::UMS_ADDR_ENHF: begin
                    st_nxt.rdata = st_r.enhf;
                end
                ums_pkg::UMS_ADDR_RXTRG: begin
                    st_nxt.rdata = st_r.rx_trig;
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Automatic RTS/DTR flow control with hysteresis.
        if (!auto_rts) begin
            st_nxt.flow_block = 1'b0;
        end else if (level >= stop_lvl) begin // RULE12 RULE19
            st_nxt.flow_block = 1'b1;
        end else if (level < go_lvl) begin // RULE12 RULE19
            st_nxt.flow_block = 1'b0;
        end

        // Automatic CTS/DSR transmit gating; the transmitter samples this
        // only between characters, so a character in flight completes.
        if (pair_sel) begin
            st_nxt.tx_halt = auto_cts & modem_in.dsr_n; // RULE20
        end else begin
            st_nxt.tx_halt = auto_cts & modem_in.cts_n; // RULE1 RULE2
        end

        // RS-485 direction sequencing.
        if (!rs485_en) begin
            st_nxt.rs_state = ums_pkg::UMS_RS_IDLE;
            st_nxt.turn_cnt = 4'h0;
        end else begin
            unique case (st_r.rs_state)
                ums_pkg::UMS_RS_IDLE: begin
                    if (tx_stat.tx_load) begin // RULE16
                        st_nxt.rs_state = ums_pkg::UMS_RS_SEND;
                    end
                end
                ums_pkg::UMS_RS_SEND: begin
                    if (tx_stat.hold_empty && tx_stat.shift_empty && !tx_stat.tx_load) begin
                        if (st_r.delay == 4'h0) begin // RULE16
                            st_nxt.rs_state = ums_pkg::UMS_RS_IDLE;
                        end else begin
                            st_nxt.rs_state = ums_pkg::UMS_RS_TURN;
                            st_nxt.turn_cnt = st_r.delay; // RULE7
                        end
                    end
                end
                ums_pkg::UMS_RS_TURN: begin
                    if (tx_stat.tx_load) begin
                        st_nxt.rs_state = ums_pkg::UMS_RS_SEND;
                    end else if (tx_stat.bit_tick) begin // RULE23
                        if (st_r.turn_cnt == 4'h1) begin
                            st_nxt.rs_state = ums_pkg::UMS_RS_IDLE;
                        end
                        st_nxt.turn_cnt = st_r.turn_cnt - 4'h1;
                    end
                end
            endcase
        end

        // Transmit interrupt source.
        if (rs485_en) begin
            st_nxt.tx_int = tx_stat.shift_empty; // RULE17
        end else begin
            st_nxt.tx_int = tx_stat.hold_empty; // RULE15
        end

        // Modem control outputs.
        st_nxt.rts_n = ~st_r.mctl[ums_pkg::UMS_MCTL_RTS];
        st_nxt.dtr_n = ~st_r.mctl[ums_pkg::UMS_MCTL_DTR];
        if (auto_rts && !pair_sel) begin
            st_nxt.rts_n = st_nxt.rts_n | st_nxt.flow_block; // RULE20
        end
        if (auto_rts && pair_sel) begin
            st_nxt.dtr_n = st_nxt.dtr_n | st_nxt.flow_block; // RULE20
        end
        if (rs485_en) begin
            st_nxt.rts_n = (st_nxt.rs_state != ums_pkg::UMS_RS_IDLE); // RULE16
        end
        if (loop_en) begin
            // Outputs go inactive while looped back internally.
            st_nxt.rts_n = 1'b1;
            st_nxt.dtr_n = 1'b1;
        end

        // IrDA receive polarity.
        st_nxt.ir_rx = ir_rx_in ^ st_r.feat[ums_pkg::UMS_FEAT_IRINV]; // RULE14
    end

    // ==========================================================================
    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ums_pkg::UMS_STATE_RST; // RULE9 RULE13
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================================
    // Outputs.
    assign rdata      = st_r.rdata;
    assign ir_rx_data = st_r.ir_rx;
    assign tx_halt    = st_r.tx_halt;
    assign tx_int     = st_r.tx_int;
    assign rts_n      = st_r.rts_n;
    assign dtr_n      = st_r.dtr_n;

endmodule : ums_modem_feature
`default_nettype wire

/* bench/ums_modem_model.sv */
// Modem side model that drives the four status pins of the line.
`timescale 1ns/10ps
`default_nettype none
module ums_modem_model (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic             [3:0] pins_set,
    input  wire logic                   pace,
    output var  ums_pkg::ums_modem_in_s modem_in
);
    // ====================
    // Pins follow the set pattern; pacing toggles clear-to-send slowly.
    logic [2:0] pace_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pace_r   <= 3'h0;
            modem_in <= 4'hf;
        end else begin
            pace_r   <= pace_r + 3'h1;
            modem_in <= pace ? {pins_set[3:1], pace_r[2]} : pins_set;
        end
    end
endmodule : ums_modem_model
`default_nettype wire

/* bench/ums_chk.sv */
// Checker that watches the ports of the modem status and feature block.
`timescale 1ns/10ps
`default_nettype none
module ums_chk (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire ums_pkg::ums_bus_s      bus,
    input wire logic             [7:0] rdata,
    input wire ums_pkg::ums_modem_in_s modem_in,
    input wire ums_pkg::ums_tx_stat_s  tx_stat,
    input wire logic                   ir_rx_in,
    input wire logic                   ir_rx_data,
    input wire logic                   tx_halt,
    input wire logic                   tx_int,
    input wire logic                   rts_n,
    input wire logic                   dtr_n
);
    // ====================
    // Shadow registers and a settle counter after reset.
    logic [7:0] mctl_r, enhf_r, feat_r, scr_r;
    logic [1:0] up_r;
    logic [3:0] mstat_v;
    logic       up;
    assign up      = up_r == 2'h3;
    assign mstat_v = mctl_r[4] ? {mctl_r[3:2], mctl_r[0], mctl_r[1]} : ~modem_in;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {mctl_r, enhf_r, feat_r, scr_r, up_r} <= {24'h00_0000, 8'hff, 2'h0};
        end else begin
            up_r <= up ? up_r : up_r + 2'h1;
            if (bus.wr && bus.addr == ums_pkg::UMS_ADDR_MCTL) mctl_r <= bus.wdata;
            if (bus.wr && bus.addr == ums_pkg::UMS_ADDR_ENHF) enhf_r <= bus.wdata;
            if (bus.wr && bus.addr == ums_pkg::UMS_ADDR_FEAT) feat_r <= bus.wdata;
            if (bus.wr && bus.addr == ums_pkg::UMS_ADDR_SCR) scr_r <= bus.wdata;
        end
    end
    // ====================
    // Assertions.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_halt_gate: assert property (up |-> tx_halt ==
        $past(enhf_r[7] & (mctl_r[2] ? modem_in.dsr_n : modem_in.cts_n)))
        else $error("Transmit halt does not follow the selected pin.");
    a_int_source: assert property (up |-> tx_int ==
        $past(feat_r[5] ? tx_stat.shift_empty : tx_stat.hold_empty))
        else $error("Transmit interrupt has the wrong source.");
    a_ir_polarity: assert property (up |-> ir_rx_data == $past(ir_rx_in ^ feat_r[4]))
        else $error("Infrared receive polarity is wrong.");
    a_mstat_read: assert property (
        bus.rd && bus.addr == ums_pkg::UMS_ADDR_MSTAT |=> rdata == {$past(mstat_v), 4'h0})
        else $error("Modem status read is wrong.");
    a_scratch_read: assert property (
        bus.rd && bus.addr == ums_pkg::UMS_ADDR_SCR |=> rdata == $past(scr_r))
        else $error("Scratch read is wrong.");
    a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("Read data is not zero outside a read answer.");
    a_rs485_load: assert property (feat_r[5] && tx_stat.tx_load |=> rts_n)
        else $error("Direction pin not high after a byte load.");
    a_plain_pins: assert property (
        up && !enhf_r[6] && !feat_r[5] && !mctl_r[4] |=>
        rts_n == !$past(mctl_r[1]) && dtr_n == !$past(mctl_r[0]))
        else $error("Control pins do not follow the control bits.");
endmodule : ums_chk
bind ums_modem_feature ums_chk i_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .modem_in(modem_in), .tx_stat(tx_stat), .ir_rx_in(ir_rx_in), .ir_rx_data(ir_rx_data),
    .tx_halt(tx_halt), .tx_int(tx_int), .rts_n(rts_n), .dtr_n(dtr_n));
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench for the modem status and feature block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ====================
    // Expected-value tables, signals, design and partner.
    localparam int HYS [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
    localparam int LVL [3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
    localparam logic [7:0] T_ENHF [4] = '{8'h00, 8'h10, 8'h00, 8'h10};
    localparam logic [7:0] T_DLY [4] = '{8'h30, 8'hf0, 8'h10, 8'h10};
    localparam int T_EXP [4] = '{0, 15, 15, 1};
    logic                   clk, rst_n, ir_rx_in, ir_rx_data, tx_halt, tx_int, rts_n, dtr_n, pace;
    ums_pkg::ums_bus_s      bus;
    ums_pkg::ums_modem_in_s modem_in;
    ums_pkg::ums_tx_stat_s  tx_stat;
    logic [7:0]             rdata, v;
    logic [6:0]             rx_level;
    logic [3:0]             pins_set;
    logic [1:0]             ix;
    logic [31:0]            lfsr_r;
    int                     fail_count, checked, n, stp, go;
    always #50 clk = ~clk;
    ums_modem_feature i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .modem_in(modem_in), .tx_stat(tx_stat), .rx_level(rx_level), .ir_rx_in(ir_rx_in),
        .ir_rx_data(ir_rx_data), .tx_halt(tx_halt), .tx_int(tx_int), .rts_n(rts_n), .dtr_n(dtr_n));
    ums_modem_model i_modem (.clk(clk), .rst_n(rst_n), .pins_set(pins_set), .pace(pace),
        .modem_in(modem_in));
    // ====================
    // Bus cycles, comparison and closing report.
    task automatic rnd(output logic [7:0] r);
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        r = lfsr_r[7:0];
    endtask : rnd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        cyc(0);
        chk(rdata, e);
    endtask : rd_chk
    task automatic lvl_chk(input int lv, input logic e, input logic sel);
        @(posedge clk);
        rx_level <= 7'(lv);
        cyc(3);
        chk(8'(sel ? dtr_n : rts_n), 8'(e));
    endtask : lvl_chk
    task automatic flow_chk(input logic [7:0] fc, input logic [7:0] trig, input logic sel);
        @(posedge clk);
        rx_level <= 7'h00;
        wr(ums_pkg::UMS_ADDR_ENHF, 8'h10);
        wr(ums_pkg::UMS_ADDR_FEAT, fc);
        wr(ums_pkg::UMS_ADDR_RXTRG, trig);
        wr(ums_pkg::UMS_ADDR_MCTL, sel ? 8'h05 : 8'h02);
        wr(ums_pkg::UMS_ADDR_ENHF, 8'h50);
        lvl_chk(stp - 1, 1'b0, sel);
        lvl_chk(stp, 1'b1, sel);
        if (go > 0) begin
            lvl_chk(go, 1'b1, sel);
            lvl_chk(go - 1, 1'b0, sel);
        end
    endtask : flow_chk
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // ====================
    // Main sequence.
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        pace = 1'b0;
        ir_rx_in = 1'b0;
        bus = '0;
        tx_stat = '{1'b1, 1'b1, 1'b0, 1'b0};
        rx_level = 7'h00;
        pins_set = 4'hf;
        lfsr_r = 32'h0000_35e2;
        fail_count = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wr(3'h7, 8'h5a);
        for (int a = 0; a < 8; a++) rd_chk(3'(a), a == 2 ? 8'hff : 8'h00);
        for (int i = 0; i < 6; i++) begin
            rnd(v);
            wr(ums_pkg::UMS_ADDR_SCR, v);
            rd_chk(ums_pkg::UMS_ADDR_SCR, v);
        end
        $display("Test registers done");
        for (int i = 0; i < 8; i++) begin
            rnd(v);
            @(posedge clk);
            pins_set <= v[3:0];
            wr(ums_pkg::UMS_ADDR_MCTL, {3'h0, 1'(i), v[7:4]});
            rd_chk(ums_pkg::UMS_ADDR_MSTAT, {i[0] ? {v[7:6], v[4], v[5]} : ~v[3:0], 4'h0});
        end
        $display("Test modem status done");
        for (int i = 0; i < 8; i++) begin
            rnd(v);
            @(posedge clk);
            pins_set <= v[3:0];
            wr(ums_pkg::UMS_ADDR_ENHF, {i[0], 7'h10});
            wr(ums_pkg::UMS_ADDR_MCTL, {5'h00, i[1], 2'h0});
            cyc(2);
            chk(8'(tx_halt), 8'(i[0] & (i[1] ? v[1] : v[0])));
        end
        wr(ums_pkg::UMS_ADDR_MCTL, 8'h00);
        @(posedge clk);
        pace <= 1'b1;
        cyc(40);
        @(posedge clk);
        pace <= 1'b0;
        $display("Test transmit gating done");
        for (int i = 0; i < 8; i++) begin
            wr(ums_pkg::UMS_ADDR_FEAT, {2'h0, i[0], i[2], 4'h0});
            @(posedge clk);
            tx_stat.shift_empty <= i[1];
            ir_rx_in <= i[1];
            cyc(2);
            chk(8'(tx_int), 8'(i[0] ? i[1] : 1'b1));
            chk(8'(ir_rx_data), 8'(i[1] ^ i[2]));
        end
        $display("Test interrupt and infrared done");
        for (int c = 0; c < 16; c++) begin
            v = HYS[c] > 32 ? 8'h0c : 8'h20;
            stp = v + HYS[c];
            go = v > HYS[c] ? v - HYS[c] : 0;
            flow_chk({4'hc, 4'(c)}, v, c % 2);
        end
        for (int t = 0; t < 3; t++) begin
            rnd(v);
            ix = t == 2 ? 2'h2 : v[1:0];
            stp = ix == 2'h3 ? 64 : LVL[t][ix + 1];
            go = LVL[t][ix == 2'h0 ? 0 : ix - 1];
            flow_chk({2'(t), 2'h0, v[7:4] | 4'h1}, {6'h00, ix}, 1'b0);
        end
        $display("Test flow control done");
        wr(ums_pkg::UMS_ADDR_FEAT, 8'h20);
        wr(ums_pkg::UMS_ADDR_MCTL, 8'h02);
        for (int r = 0; r < 4; r++) begin
            wr(ums_pkg::UMS_ADDR_ENHF, T_ENHF[r]);
            wr(ums_pkg::UMS_ADDR_MSTAT, T_DLY[r]);
            @(posedge clk);
            tx_stat <= '{1'b0, 1'b0, 1'b1, 1'b0};
            @(posedge clk);
            tx_stat.tx_load <= 1'b0;
            cyc(0);
            chk(8'(rts_n), 8'h01);
            @(posedge clk);
            tx_stat <= '{1'b1, 1'b1, 1'b0, 1'b0};
            n = 0;
            for (int k = 0; k < 80 && rts_n !== 1'b0; k++) begin
                @(posedge clk);
                tx_stat.bit_tick <= k % 4 == 2;
                n += int'(k % 4 == 2);
                @(negedge clk);
            end
            chk(8'(n), 8'(T_EXP[r]));
            if (rts_n !== 1'b0) begin
                fail_count++;
                test_done();
            end
        end
        $display("Test turnaround delay done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
